// ==== verilog/xdm_pin_mux.sv ====
// external data pin and latched address pin function multiplexer
`timescale 1ns/1ps
module xdm_pin_mux (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire xdm_pkg::xdm_cycle_t cycle_in,
  input  wire logic [7:0]          xbus_wdata,
  output logic      [7:0]          xbus_rdata,
  input  wire logic                prog_irq_one_in,
  input  wire logic                primary_drive_dma_ack,
  input  wire logic                secondary_drive_dma_ack,
  input  wire logic                split_grant_busy_strap,
  input  wire logic                arb_grant_req,
  output logic                     arb_grant_ok,
  output logic                     primary_drive_dma_req,
  output logic                     secondary_drive_dma_req,
  output logic                     pci_bus_busy,
  input  wire logic [7:0]          ext_data_bus_in,
  output logic      [7:0]          ext_data_bus_out,
  output logic      [7:0]          ext_data_bus_oe,
  output logic      [6:0]          isa_latched_addr_out,
  output logic                     isa_latched_addr_oe
);
  import xdm_pkg::*;

  default clocking mux_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // pin synchroniser and bus front end
  // ----------------------------------------------------------------
  logic [7:0]  pin_s;
  logic        strap_s;
  logic        wr_en;
  logic        rd_en;
  logic        bad_addr;
  logic [11:0] word_addr;

  xdm_sync #(.WIDTH(9)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({split_grant_busy_strap, ext_data_bus_in}),
    .sync_out ({strap_s, pin_s})
  );

  xdm_apb_slave u_apb (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .bad_addr  (bad_addr),
    .word_addr (word_addr)
  );

  // ----------------------------------------------------------------
  // power-up strap capture
  // ----------------------------------------------------------------
  // sampled once, a few cycles after release, so the sync has settled
  logic [1:0] strap_cnt_reg;
  logic       strap_done_reg;
  logic       split_busy_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
      split_busy_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h3) begin
        strap_done_reg <= 1'b1;
        split_busy_reg <= !strap_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] cfg_reg;
  logic [1:0]  gpio_reg;

  wire xbus_mode  = cfg_reg[XDM_CFG_XBUS_BIT];
  wire p6_gp      = cfg_reg[XDM_CFG_P6GP_BIT];
  wire ide_dma    = cfg_reg[XDM_CFG_IDEDMA_BIT];
  wire p2_gp      = cfg_reg[XDM_CFG_P2GP_BIT];
  wire g1_out     = cfg_reg[XDM_CFG_G1OE_BIT];
  wire g2_out     = cfg_reg[XDM_CFG_G2OE_BIT];
  wire g1_active  = !xbus_mode && !split_busy_reg && p6_gp;
  wire g2_active  = !xbus_mode && ide_dma && p2_gp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= XDM_CFG_RST;
    end else if (wr_en && word_addr == XDM_CFG_OFF) begin
      cfg_reg <= {26'h0, pwdata[5:0]};
    end
  end

  // input-mode pins keep loading the line; writes land on any pin that is not an active input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_reg <= XDM_GPIO_RST[1:0];
    end else begin
      if (g1_active && !g1_out) begin
        gpio_reg[XDM_GPIO_G1_BIT] <= pin_s[6];
      end else if (wr_en && word_addr == XDM_GPIO_OFF) begin
        gpio_reg[XDM_GPIO_G1_BIT] <= pwdata[XDM_GPIO_G1_BIT];
      end
      if (g2_active && !g2_out) begin
        gpio_reg[XDM_GPIO_G2_BIT] <= pin_s[2];
      end else if (wr_en && word_addr == XDM_GPIO_OFF) begin
        gpio_reg[XDM_GPIO_G2_BIT] <= pwdata[XDM_GPIO_G2_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // apb read path, zero wait
  // ----------------------------------------------------------------
  logic [31:0] rd_next;

  always_comb begin
    rd_next = 32'h0;
    case (word_addr)
      XDM_CFG_OFF:    rd_next = cfg_reg;
      XDM_GPIO_OFF:   rd_next = {30'h0, gpio_reg};
      XDM_STATUS_OFF: rd_next = {28'h0, secondary_drive_dma_req,
                                 primary_drive_dma_req, pci_bus_busy,
                                 split_busy_reg};
      default:        rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && bad_addr;
      if (rd_en) begin
        prdata <= rd_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // data pin function selection
  // ----------------------------------------------------------------
  xdm_pins_t pins_next;

  always_comb begin
    pins_next = '{dout: 8'h00, oe: 8'h00};
    if (xbus_mode) begin
      // write cycle from isa: buffer drives pins toward the device
      pins_next.dout = xbus_wdata;
      pins_next.oe   = {8{cycle_in.xbus_cycle && !cycle_in.xbus_read}};
      // busy strap owns pin six even in bus mode
      if (split_busy_reg) begin
        pins_next.oe[6] = 1'b0;
      end
    end else begin
      pins_next.dout[1] = cycle_in.xbus_cycle;
      pins_next.oe[1]   = 1'b1;
      pins_next.dout[0] = cycle_in.xbus_read;
      pins_next.oe[0]   = 1'b1;
      if (!split_busy_reg) begin
        pins_next.dout[6] = p6_gp ? gpio_reg[XDM_GPIO_G1_BIT]
                                  : prog_irq_one_in;
        pins_next.oe[6]   = p6_gp ? g1_out : 1'b1;
      end
      if (ide_dma) begin
        pins_next.dout[4] = primary_drive_dma_ack;
        pins_next.oe[4]   = 1'b1;
        pins_next.dout[2] = p2_gp ? gpio_reg[XDM_GPIO_G2_BIT]
                                  : secondary_drive_dma_ack;
        pins_next.oe[2]   = p2_gp ? g2_out : 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin registers, inputs and arbiter gate
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_data_bus_out        <= 8'h00;
      ext_data_bus_oe         <= 8'h00;
      xbus_rdata              <= 8'h00;
      pci_bus_busy            <= 1'b0;
      primary_drive_dma_req   <= 1'b0;
      secondary_drive_dma_req <= 1'b0;
      arb_grant_ok            <= 1'b0;
    end else begin
      ext_data_bus_out        <= pins_next.dout;
      ext_data_bus_oe         <= pins_next.oe;
      xbus_rdata              <= xbus_mode ? pin_s : 8'h00;
      pci_bus_busy            <= split_busy_reg && pin_s[6];
      primary_drive_dma_req   <= !xbus_mode && ide_dma && pin_s[5];
      secondary_drive_dma_req <= !xbus_mode && ide_dma && pin_s[3];
      // busy seen this edge blocks the grant on the same edge
      arb_grant_ok <= arb_grant_req && !(split_busy_reg && pin_s[6]);
    end
  end

  // ----------------------------------------------------------------
  // latched address pins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isa_latched_addr_out <= 7'h00;
      isa_latched_addr_oe  <= 1'b0;
    end else begin
      isa_latched_addr_oe <= 1'b1;
      if (cycle_in.ide_cycle) begin
        isa_latched_addr_out <= {cycle_in.pcs0, cycle_in.pcs1,
                                 cycle_in.scs0, cycle_in.scs1,
                                 cycle_in.reg_sel};
      end else begin
        isa_latched_addr_out <= cycle_in.isa_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence busy_seen_s;
    split_busy_reg && pin_s[6];
  endsequence

  busy_blocks_grant_a: assert property (
    busy_seen_s |=> !arb_grant_ok)
    else $error("grant given while bus busy");
  xbus_pins_a: assert property (
    xbus_mode |=> xbus_rdata == $past(pin_s))
    else $error("external bus data not passed");
  gpio_in_load_a: assert property (
    (g1_active && !g1_out) |=> gpio_reg[0] == $past(pin_s[6]))
    else $error("gpio input not loaded");
  pin6_irq_a: assert property (
    (!xbus_mode && !split_busy_reg && !p6_gp) |=>
      ext_data_bus_out[6] == $past(prog_irq_one_in))
    else $error("pin six irq not driven");
  strap_drop_a: assert property (
    split_busy_reg |=> !ext_data_bus_oe[6])
    else $error("pin six driven in busy mode");
  req0_pass_a: assert property (
    (!xbus_mode && ide_dma) |=>
      primary_drive_dma_req == $past(pin_s[5]))
    else $error("primary dma request lost");
  ack1_pass_a: assert property (
    (!xbus_mode && ide_dma && !p2_gp) |=>
      ext_data_bus_out[2] == $past(secondary_drive_dma_ack)
      && ext_data_bus_oe[2])
    else $error("secondary ack not driven");
  buf_enable_a: assert property (
    !xbus_mode |=> ext_data_bus_out[1] == $past(cycle_in.xbus_cycle)
      && ext_data_bus_out[0] == $past(cycle_in.xbus_read))
    else $error("buffer control wrong");
  ide_addr_a: assert property (
    cycle_in.ide_cycle |=>
      isa_latched_addr_out[2:0] == $past(cycle_in.reg_sel))
    else $error("ide register select wrong");
endmodule // xdm_pin_mux

// ==== verilog/xdm_pkg.sv ====
// package: register map, field positions, reset values and carriers
package xdm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] XDM_CFG_OFF    = 12'h000;
  localparam logic [11:0] XDM_GPIO_OFF   = 12'h004;
  localparam logic [11:0] XDM_STATUS_OFF = 12'h008;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int XDM_CFG_XBUS_BIT   = 0;  // external data bus option
  localparam int XDM_CFG_P6GP_BIT   = 1;  // pin six: 1 general pin, 0 irq
  localparam int XDM_CFG_IDEDMA_BIT = 2;  // pins five..two carry ide dma
  localparam int XDM_CFG_P2GP_BIT   = 3;  // pin two general pin over ack
  localparam int XDM_CFG_G1OE_BIT   = 4;  // general pin one drives out
  localparam int XDM_CFG_G2OE_BIT   = 5;  // general pin two drives out
  localparam logic [31:0] XDM_CFG_RST  = 32'h0000_0001;
  localparam logic [31:0] XDM_GPIO_RST = 32'h0000_0000;

  // gpio register bits
  localparam int XDM_GPIO_G1_BIT = 0;
  localparam int XDM_GPIO_G2_BIT = 1;

  // status bits
  localparam int XDM_ST_STRAP_BIT = 0;
  localparam int XDM_ST_BUSY_BIT  = 1;
  localparam int XDM_ST_REQ0_BIT  = 2;
  localparam int XDM_ST_REQ1_BIT  = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ide_cycle;   // current cycle is an ide access
    logic       xbus_cycle;  // cycle targets external data bus devices
    logic       xbus_read;   // 1 read toward the isa side
    logic [6:0] isa_addr;    // isa latched address bits 23..17
    logic       pcs0;
    logic       pcs1;
    logic       scs0;
    logic       scs1;
    logic [2:0] reg_sel;     // ide register select
  } xdm_cycle_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } xdm_pins_t;

endpackage

// ==== verilog/xdm_sync.sv ====
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module xdm_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // meta stage feeds the second flop only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // xdm_sync

// ==== verilog/xdm_apb_slave.sv ====
// apb slave front end: single-wait-free decode into strobes
`timescale 1ns/1ps
module xdm_apb_slave (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             wr_en,
  output logic             rd_en,
  output logic             bad_addr,
  output logic [11:0]      word_addr
);
  import xdm_pkg::*;

  function automatic logic mapped(input logic [11:0] a);
    return (a == XDM_CFG_OFF) || (a == XDM_GPIO_OFF) ||
           (a == XDM_STATUS_OFF);
  endfunction

  always_comb begin
    word_addr = {paddr[11:2], 2'b00};
    wr_en     = psel && penable && pwrite && mapped(word_addr);
    rd_en     = psel && !penable && !pwrite;
    bad_addr  = !mapped(word_addr);
  end

  // unused: presetn and pclk kept for a uniform header
  logic unused_ok;
  assign unused_ok = pclk ^ presetn;
endmodule // xdm_apb_slave

// ==== testbench/xdm_pin_model.sv ====
// far-side model: isa, ide and bridge parties sharing the data pins
`timescale 1ns/1ps
module xdm_pin_model (
  input  wire logic       pclk,
  input  wire logic [7:0] dut_out,
  input  wire logic [7:0] dut_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_level
);
  // ----------------------------------------------------------------
  // undriven lines float: a changing pattern, never the last value
  // ----------------------------------------------------------------
  logic [7:0] float_reg = 8'h55;

  always_ff @(posedge pclk) begin
    float_reg <= ~float_reg;
  end

  // ----------------------------------------------------------------
  // wire resolution; ext_en marks the far party driving a line:
  // rom data, drive dma requests, bridge busy level
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = dut_oe[i] ? dut_out[i] :
                     (ext_en[i] ? ext_val[i] : float_reg[i]);
    end
  end
endmodule  // xdm_pin_model

// ==== testbench/xd_la_pin_function_mux_tb.sv ====
// self-checking bench for the data and latched address pin mux
`timescale 1ns/1ps
module xd_la_pin_function_mux_tb;
  import xdm_pkg::*;
  // ----------------------------------------------------------------
  // stimulus rows: config, gpio, irq/acks/cycle, far drive, expects
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] cfg;
    logic [1:0] gp;
    logic [4:0] ctl;
    logic [7:0] drv;
    logic [7:0] den;
    logic [7:0] msk;
    logic [7:0] eoe;
    logic [7:0] eout;
    logic [1:0] ereq;
  } xdm_row_t;
  xdm_row_t rows [7] = '{
    {6'h00, 2'b00, 5'b10010, 8'h00, 8'h00, 8'h43, 8'h43, 8'h42, 2'b00},
    {6'h00, 2'b00, 5'b00001, 8'h00, 8'h00, 8'h43, 8'h43, 8'h01, 2'b00},
    {6'h04, 2'b00, 5'b01000, 8'h20, 8'h28, 8'h3c, 8'h14, 8'h10, 2'b10},
    {6'h04, 2'b00, 5'b00100, 8'h08, 8'h28, 8'h3c, 8'h14, 8'h04, 2'b01},
    {6'h2c, 2'b10, 5'b00000, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 2'b00},
    {6'h12, 2'b01, 5'b00000, 8'h00, 8'h00, 8'h40, 8'h40, 8'h40, 2'b00},
    {6'h02, 2'b00, 5'b00000, 8'h40, 8'h40, 8'h40, 8'h00, 8'h00, 2'b00}};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  xdm_cycle_t  cyc = '0;
  logic [7:0]  xbus_wdata = 8'h00;
  logic [7:0]  xbus_rdata;
  logic        irq_one = 1'b0;
  logic        ack0 = 1'b0;
  logic        ack1 = 1'b0;
  logic        strap = 1'b1;
  logic        grant_req = 1'b0;
  logic        grant_ok;
  logic        req0;
  logic        req1;
  logic        busy;
  logic [7:0]  pin_level;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  far_val = 8'h00;
  logic [7:0]  far_en = 8'h00;
  logic [6:0]  la_out;
  logic        la_oe;
  logic [31:0] rdat;
  logic        rerr;
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #4 pclk = ~pclk;

  xdm_pin_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cycle_in(cyc),
    .xbus_wdata(xbus_wdata), .xbus_rdata(xbus_rdata),
    .prog_irq_one_in(irq_one), .primary_drive_dma_ack(ack0),
    .secondary_drive_dma_ack(ack1), .split_grant_busy_strap(strap),
    .arb_grant_req(grant_req), .arb_grant_ok(grant_ok),
    .primary_drive_dma_req(req0), .secondary_drive_dma_req(req1),
    .pci_bus_busy(busy), .ext_data_bus_in(pin_level),
    .ext_data_bus_out(pin_out), .ext_data_bus_oe(pin_oe),
    .isa_latched_addr_out(la_out), .isa_latched_addr_oe(la_oe));

  xdm_pin_model far (.pclk(pclk), .dut_out(pin_out), .dut_oe(pin_oe),
    .ext_val(far_val), .ext_en(far_en), .pin_level(pin_level));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; idles a cycle after so no signal is set twice
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      test_done();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic settle;
    repeat (5) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("la_oe", la_oe, 1'b1);
    apb(1'b0, XDM_CFG_OFF, 32'h0);
    chk("cfg_rst", rdat, XDM_CFG_RST);
    apb(1'b0, XDM_GPIO_OFF, 32'h0);
    chk("gpio_rst", rdat, XDM_GPIO_RST);
    // external bus write then read, bus option at reset
    cyc.xbus_cycle <= 1'b1;
    xbus_wdata <= 8'ha5;
    settle();
    chk("xbus_oe", pin_oe, 8'hff);
    chk("xbus_out", pin_out, 8'ha5);
    cyc.xbus_read <= 1'b1;
    far_val <= 8'h3c;
    far_en <= 8'hff;
    settle();
    chk("xbus_rd_oe", pin_oe, 8'h00);
    chk("xbus_rdata", xbus_rdata, 8'h3c);
    // table of pin functions with the bus option off
    foreach (rows[k]) begin
      apb(1'b1, XDM_CFG_OFF, {26'h0, rows[k].cfg});
      apb(1'b1, XDM_GPIO_OFF, {30'h0, rows[k].gp});
      {irq_one, ack0, ack1, cyc.xbus_cycle, cyc.xbus_read} <= rows[k].ctl;
      far_val <= rows[k].drv;
      far_en <= rows[k].den;
      settle();
      chk("row_oe", pin_oe & rows[k].msk, rows[k].eoe);
      chk("row_out", pin_out & pin_oe & rows[k].msk,
          rows[k].eout);
      if (rows[k].den[5]) begin
        chk("dma_req", {req0, req1}, rows[k].ereq);
      end
    end
    // general pin one as input follows the line level
    apb(1'b0, XDM_GPIO_OFF, 32'h0);
    chk("gp_in_hi", rdat[XDM_GPIO_G1_BIT], 1'b1);
    far_val <= 8'h00;
    settle();
    apb(1'b0, XDM_GPIO_OFF, 32'h0);
    chk("gp_in_lo", rdat[XDM_GPIO_G1_BIT], 1'b0);
    // latched address outside and during ide cycles
    cyc.isa_addr <= 7'h55;
    settle();
    chk("la_isa", la_out, 7'h55);
    {cyc.ide_cycle, cyc.pcs0, cyc.pcs1, cyc.scs0, cyc.scs1} <= 5'b11001;
    cyc.reg_sel <= 3'b101;
    settle();
    chk("la_ide", la_out, 7'b1001101);
    // unmapped place is refused
    apb(1'b0, 12'h00c, 32'h0);
    chk("bad_addr", rerr, 1'b1);
    // strap low at power-up: pin six becomes the busy input, bus mode too
    strap <= 1'b0;
    cyc.xbus_cycle <= 1'b1;
    far_val <= 8'h40;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    settle();
    chk("busy_xbus_oe", pin_oe, 8'hbf);
    chk("busy_xbus", busy, 1'b1);
    apb(1'b1, XDM_CFG_OFF, 32'h0);
    grant_req <= 1'b1;
    far_val <= 8'h40;
    far_en <= 8'h40;
    settle();
    chk("busy_oe", pin_oe[6], 1'b0);
    chk("busy_hi", {busy, grant_ok}, 2'b10);
    far_val <= 8'h00;
    settle();
    chk("busy_lo", {busy, grant_ok}, 2'b01);
    test_done();
  end
endmodule  // xd_la_pin_function_mux_tb
